// ==== hdl/smb_pkg.sv ====
package smb_pkg;

   // sizing of the banks
   localparam int NUM_TRIGGERS = 4;
   localparam int NUM_MODULES = 4;
   localparam int NUM_BITSTREAMS = 8;
   localparam int TRIG_IDX_W = 2;
   localparam int MOD_IDX_W = 2;
   localparam int BS_IDX_W = 3;
   localparam int TRIG_MAP_W = $clog2(NUM_TRIGGERS + 1) - 1;
   localparam int SEL_W = 16;
   localparam int DATA_W = 32;

   // device family: 1 = two bitstreams per module, 0 = one
   localparam bit TWO_BS_FAMILY_DEFAULT = 1'b1;

   // bank codes on the bank select port
   localparam logic [1:0] BANK_TRIGGER = 2'h1;
   localparam logic [1:0] BANK_MODULE = 2'h2;
   localparam logic [1:0] BANK_BITSTREAM = 2'h3;

   // register select low bits
   localparam logic SEL_MOD_LINK = 1'b0;
   localparam logic SEL_MOD_CTRL = 1'b1;
   localparam logic [1:0] SEL_BS_ORDINAL = 2'h0;
   localparam logic [1:0] SEL_BS_LOCATION = 2'h1;
   localparam logic [1:0] SEL_BS_LENGTH = 2'h2;

   // bitstream link field layout
   localparam int LOAD_ROW_LSB = 0;
   localparam int LOAD_ROW_MSB = 15;
   localparam int CLEAR_ROW_LSB = 16;
   localparam int CLEAR_ROW_MSB = 31;

   // module sequence control field layout
   localparam int CTRL_W = 13;
   localparam int CTRL_SHUTDOWN_LSB = 0;
   localparam int CTRL_SHUTDOWN_MSB = 1;
   localparam int CTRL_STARTUP_BIT = 2;
   localparam int CTRL_RESET_LSB = 3;
   localparam int CTRL_RESET_MSB = 4;
   localparam int CTRL_DURATION_LSB = 5;
   localparam int CTRL_DURATION_MSB = 12;

   // shutdown requirement codes
   localparam logic [1:0] SHUT_NONE = 2'h0;
   localparam logic [1:0] SHUT_HW = 2'h1;
   localparam logic [1:0] SHUT_HW_SW = 2'h2;
   localparam logic [1:0] SHUT_SW_HW = 2'h3;

   // reset requirement codes
   localparam logic [1:0] RST_NONE = 2'h0;
   localparam logic [1:0] RST_RESERVED = 2'h1;
   localparam logic [1:0] RST_ACTIVE_LOW = 2'h2;
   localparam logic [1:0] RST_ACTIVE_HIGH = 2'h3;

   // values after reset
   localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;

endpackage

// ==== hdl/smb_regs.sv ====
`timescale 1ns/1ns
module smb_regs #(
   parameter bit TWO_BS_FAMILY = smb_pkg::TWO_BS_FAMILY_DEFAULT
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // manager state
   input wire logic shutdown_i,
   // register select access
   input wire logic [1:0] reg_bank_i,
   input wire logic [smb_pkg::SEL_W-1:0] reg_sel_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [smb_pkg::DATA_W-1:0] reg_wdata_i,
   output logic [smb_pkg::DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // stored contents for the sequencer
   output logic [smb_pkg::NUM_TRIGGERS*smb_pkg::TRIG_MAP_W-1:0] trigger_map_entry_o,
   output logic [smb_pkg::NUM_MODULES*16-1:0] load_bitstream_row_o,
   output logic [smb_pkg::NUM_MODULES*16-1:0] clearing_bitstream_row_o,
   output logic [smb_pkg::NUM_MODULES*smb_pkg::CTRL_W-1:0] module_sequence_control_o,
   output logic [smb_pkg::NUM_BITSTREAMS-1:0] bitstream_ordinal_o,
   output logic [smb_pkg::NUM_BITSTREAMS*32-1:0] bitstream_location_o,
   output logic [smb_pkg::NUM_BITSTREAMS*32-1:0] bitstream_length_o
);

   localparam int TW = smb_pkg::TRIG_MAP_W;
   localparam int CW = smb_pkg::CTRL_W;

   // storage
   logic [TW-1:0] trig_q [smb_pkg::NUM_TRIGGERS];
   logic [15:0] load_row_q [smb_pkg::NUM_MODULES];
   logic [15:0] clear_row_q [smb_pkg::NUM_MODULES];
   logic [CW-1:0] ctrl_q [smb_pkg::NUM_MODULES];
   logic ordinal_q [smb_pkg::NUM_BITSTREAMS];
   logic [31:0] location_q [smb_pkg::NUM_BITSTREAMS];
   logic [31:0] length_q [smb_pkg::NUM_BITSTREAMS];
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic rvalid_q;

   // row and register decode
   wire access_ok = shutdown_i;
   wire [15:0] trig_row = reg_sel_i;
   wire [14:0] mod_row = reg_sel_i[15:1];
   wire mod_reg = reg_sel_i[0];
   wire [13:0] bs_row = reg_sel_i[15:2];
   wire [1:0] bs_reg = reg_sel_i[1:0];
   wire trig_in = trig_row < 16'(smb_pkg::NUM_TRIGGERS);
   wire mod_in = mod_row < 15'(smb_pkg::NUM_MODULES);
   wire bs_in = bs_row < 14'(smb_pkg::NUM_BITSTREAMS);
   wire [smb_pkg::TRIG_IDX_W-1:0] trig_idx = trig_row[smb_pkg::TRIG_IDX_W-1:0];
   wire [smb_pkg::MOD_IDX_W-1:0] mod_idx = mod_row[smb_pkg::MOD_IDX_W-1:0];
   wire [smb_pkg::BS_IDX_W-1:0] bs_idx = bs_row[smb_pkg::BS_IDX_W-1:0];

   wire trig_hit = access_ok && (reg_bank_i == smb_pkg::BANK_TRIGGER) && trig_in;
   wire mod_hit = access_ok && (reg_bank_i == smb_pkg::BANK_MODULE) && mod_in;
   wire bs_hit = access_ok && (reg_bank_i == smb_pkg::BANK_BITSTREAM) && bs_in;

   wire wr_link = reg_wr_i && mod_hit && (mod_reg == smb_pkg::SEL_MOD_LINK);
   wire wr_ctrl = reg_wr_i && mod_hit && (mod_reg == smb_pkg::SEL_MOD_CTRL);
   wire wr_ord = reg_wr_i && bs_hit && (bs_reg == smb_pkg::SEL_BS_ORDINAL)
      && TWO_BS_FAMILY;
   wire wr_loc = reg_wr_i && bs_hit && (bs_reg == smb_pkg::SEL_BS_LOCATION);
   wire wr_len = reg_wr_i && bs_hit && (bs_reg == smb_pkg::SEL_BS_LENGTH);

   // read values per bank
   wire [31:0] rd_trig = {{(32 - TW){1'b0}}, trig_q[trig_idx]};
   wire [15:0] rd_clear = TWO_BS_FAMILY ? clear_row_q[mod_idx] : 16'h0000;
   wire [31:0] rd_link = {rd_clear, load_row_q[mod_idx]};
   wire [31:0] rd_ctrl = {{(32 - CW){1'b0}}, ctrl_q[mod_idx]};
   wire rd_ord_bit = TWO_BS_FAMILY ? ordinal_q[bs_idx] : 1'b0;
   wire [31:0] rd_ord = {31'h0000_0000, rd_ord_bit};
   wire [31:0] rd_mod = (mod_reg == smb_pkg::SEL_MOD_LINK) ? rd_link : rd_ctrl;
   wire [31:0] rd_bs =
      (bs_reg == smb_pkg::SEL_BS_ORDINAL) ? rd_ord :
      (bs_reg == smb_pkg::SEL_BS_LOCATION) ? location_q[bs_idx] :
      (bs_reg == smb_pkg::SEL_BS_LENGTH) ? length_q[bs_idx] :
      32'h0000_0000;

   assign rdata_d = trig_hit ? rd_trig :
                    mod_hit ? rd_mod :
                    bs_hit ? rd_bs :
                    32'h0000_0000;

   // registered read answer
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rdata_q <= smb_pkg::REG_RESET;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= reg_rd_i;
         rdata_q <= reg_rd_i ? rdata_d : smb_pkg::REG_RESET;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;

   // trigger to module map
   genvar t;
   generate
      for (t = 0; t < smb_pkg::NUM_TRIGGERS; t++)
      begin : g_trig
         wire wr_t = reg_wr_i && trig_hit && (trig_idx == smb_pkg::TRIG_IDX_W'(t));
         always_ff @(posedge clk_i)
         begin
            if (sys_rst_i)
               trig_q[t] <= '0;
            else if (wr_t)
               trig_q[t] <= reg_wdata_i[TW-1:0];
         end
         assign trigger_map_entry_o[t*TW +: TW] = trig_q[t];
      end
   endgenerate

   // module information rows
   genvar m;
   generate
      for (m = 0; m < smb_pkg::NUM_MODULES; m++)
      begin : g_mod
         wire sel_m = (mod_idx == smb_pkg::MOD_IDX_W'(m));
         always_ff @(posedge clk_i)
         begin
            if (sys_rst_i)
            begin
               load_row_q[m] <= 16'h0000;
               clear_row_q[m] <= 16'h0000;
               ctrl_q[m] <= smb_pkg::CTRL_RESET;
            end
            else
            begin
               if (wr_link && sel_m)
               begin
                  load_row_q[m] <= reg_wdata_i[smb_pkg::LOAD_ROW_MSB:smb_pkg::LOAD_ROW_LSB];
                  if (TWO_BS_FAMILY)
                     clear_row_q[m] <=
                        reg_wdata_i[smb_pkg::CLEAR_ROW_MSB:smb_pkg::CLEAR_ROW_LSB];
               end
               if (wr_ctrl && sel_m)
                  ctrl_q[m] <= reg_wdata_i[CW-1:0];
            end
         end
         assign load_bitstream_row_o[m*16 +: 16] = load_row_q[m];
         assign clearing_bitstream_row_o[m*16 +: 16] = clear_row_q[m];
         assign module_sequence_control_o[m*CW +: CW] = ctrl_q[m];
      end
   endgenerate

   // bitstream information rows
   genvar b;
   generate
      for (b = 0; b < smb_pkg::NUM_BITSTREAMS; b++)
      begin : g_bs
         wire sel_b = (bs_idx == smb_pkg::BS_IDX_W'(b));
         always_ff @(posedge clk_i)
         begin
            if (sys_rst_i)
            begin
               ordinal_q[b] <= 1'b0;
               location_q[b] <= smb_pkg::REG_RESET;
               length_q[b] <= smb_pkg::REG_RESET;
            end
            else
            begin
               if (wr_ord && sel_b)
                  ordinal_q[b] <= reg_wdata_i[0];
               if (wr_loc && sel_b)
                  location_q[b] <= reg_wdata_i;
               if (wr_len && sel_b)
                  length_q[b] <= reg_wdata_i;
            end
         end
         assign bitstream_ordinal_o[b] = ordinal_q[b];
         assign bitstream_location_o[b*32 +: 32] = location_q[b];
         assign bitstream_length_o[b*32 +: 32] = length_q[b];
      end
   endgenerate

endmodule

// ==== verif/smb_regs_props.sv ====
`timescale 1ns/1ns
module smb_regs_props (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // access port
   input wire logic shutdown_i,
   input wire logic [1:0] reg_bank_i,
   input wire logic [15:0] reg_sel_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   // stored contents
   input wire logic [7:0] trigger_map_entry_o,
   input wire logic [51:0] module_sequence_control_o,
   input wire logic [7:0] bitstream_ordinal_o
);
   wire logic rd_on = reg_rd_i && shutdown_i;
   wire logic wr_on = reg_wr_i && shutdown_i;
   wire logic [67:0] store = {trigger_map_entry_o, module_sequence_control_o, bitstream_ordinal_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_closed_read_zero: assert property (reg_rd_i && !shutdown_i
      |=> reg_rvalid_o && reg_rdata_o == 0) else $error("closed read not zero");
   a_closed_write_drop: assert property (reg_wr_i && !shutdown_i |=> $stable(store))
      else $error("closed write landed");
   a_trig_width: assert property (rd_on && reg_bank_i == 2'h1
      |=> reg_rdata_o[31:2] == 0) else $error("trigger map high bits set");
   a_ctrl_top_zero: assert property (rd_on && reg_bank_i == 2'h2 && reg_sel_i[0]
      |=> reg_rdata_o[31:13] == 0) else $error("control high bits set");
   a_ctrl_write_lands: assert property (wr_on && reg_bank_i == 2'h2 && reg_sel_i == 16'h0001
      |=> module_sequence_control_o[12:0] == 13'($past(reg_wdata_i))) else $error("control lost");
   a_ordinal_lands: assert property (wr_on && reg_bank_i == 2'h3 && reg_sel_i == 16'h0000
      |=> bitstream_ordinal_o[0] == 1'($past(reg_wdata_i))) else $error("ordinal lost");
   a_ordinal_top_zero: assert property (rd_on && reg_bank_i == 2'h3 && reg_sel_i[1:0] == 2'h0
      |=> reg_rdata_o[31:1] == 0) else $error("ordinal high bits set");
   a_sel_three_zero: assert property (rd_on && reg_bank_i == 2'h3 && reg_sel_i[1:0] == 2'h3
      |=> reg_rdata_o == 0) else $error("unused select not zero");
   a_range_drop: assert property (reg_wr_i && reg_bank_i == 2'h1 && reg_sel_i >= 16'h0004
      |=> $stable(trigger_map_entry_o)) else $error("out of range write landed");
   c_ctrl_write: cover property (wr_on && reg_bank_i == 2'h2);
   c_closed_read: cover property (reg_rd_i && !shutdown_i);
   c_bs_read: cover property (rd_on && reg_bank_i == 2'h3);
endmodule
bind smb_regs smb_regs_props smb_regs_props_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .shutdown_i(shutdown_i), .reg_bank_i(reg_bank_i), .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .trigger_map_entry_o(trigger_map_entry_o),
   .module_sequence_control_o(module_sequence_control_o), .bitstream_ordinal_o(bitstream_ordinal_o));

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic shutdown_i = 1'b1;
   logic [1:0] reg_bank_i = 2'h0;
   logic [15:0] reg_sel_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic [31:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic [7:0] trigger_map_entry_o;
   logic [51:0] module_sequence_control_o;
   logic [63:0] load_bitstream_row_o;
   logic [63:0] clearing_bitstream_row_o;
   logic [255:0] bitstream_location_o;
   logic [255:0] bitstream_length_o;
   logic [7:0] bitstream_ordinal_o;
   int n_mismatch = 0;
   int comparisons = 0;
   smb_regs smb_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .shutdown_i(shutdown_i),
      .reg_bank_i(reg_bank_i), .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .trigger_map_entry_o(trigger_map_entry_o), .load_bitstream_row_o(load_bitstream_row_o),
      .clearing_bitstream_row_o(clearing_bitstream_row_o),
      .module_sequence_control_o(module_sequence_control_o),
      .bitstream_ordinal_o(bitstream_ordinal_o), .bitstream_location_o(bitstream_location_o),
      .bitstream_length_o(bitstream_length_o));
   initial forever #5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] b, input logic [15:0] s, input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_bank_i <= b;
      reg_sel_i <= s;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] b, input logic [15:0] s, input logic [31:0] e);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_bank_i <= b;
      reg_sel_i <= s;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk({31'h0000_0000, reg_rvalid_o}, 32'h0000_0001);
      chk(reg_rvalid_o ? reg_rdata_o : ~e, e);
   endtask
   task automatic t_trig;
      wr(2'h1, 16'h0003, 32'hFFFF_FFFF);
      rd(2'h1, 16'h0003, 32'h0000_0003);
      wr(2'h1, 16'h0004, 32'h0000_0001);
      rd(2'h1, 16'h0004, 32'h0000_0000);
      @(posedge clk_i) shutdown_i <= 1'b0;
      wr(2'h1, 16'h0003, 32'h0000_0000);
      rd(2'h1, 16'h0003, 32'h0000_0000);
      @(posedge clk_i) shutdown_i <= 1'b1;
      rd(2'h1, 16'h0003, 32'h0000_0003);
      $display("trigger map test done");
   endtask
   task automatic t_mod;
      logic [31:0] d;
      wr(2'h2, 16'h0004, 32'hABCD_1234);
      rd(2'h2, 16'h0004, 32'hABCD_1234);
      chk({16'h0000, load_bitstream_row_o[47:32]}, 32'h0000_1234);
      chk({16'h0000, clearing_bitstream_row_o[47:32]}, 32'h0000_ABCD);
      wr(2'h2, 16'h0001, 32'hFFFF_FFFF);
      #1;
      chk({19'h0_0000, module_sequence_control_o[12:0]}, 32'h0000_1FFF);
      for (int i = 0; i < 4; i++)
      begin
         d = {19'h0_0000, (i == 3) ? 8'hFF : 8'(i), 2'(i), i[0], 2'(i)};
         wr(2'h2, 16'h0007, d | 32'hFFFF_E000);
         #1;
         chk({19'h0_0000, module_sequence_control_o[51:39]}, d);
         rd(2'h2, 16'h0007, d);
      end
      @(posedge clk_i) shutdown_i <= 1'b0;
      wr(2'h2, 16'h0004, 32'h0000_0000);
      rd(2'h2, 16'h0004, 32'h0000_0000);
      @(posedge clk_i) shutdown_i <= 1'b1;
      rd(2'h2, 16'h0004, 32'hABCD_1234);
      $display("module info test done");
   endtask
   task automatic t_bs;
      wr(2'h3, 16'h001D, 32'hDEAD_BEEF);
      wr(2'h3, 16'h001E, 32'hFFFF_FFFF);
      wr(2'h3, 16'h001C, 32'hFFFF_FFFF);
      wr(2'h3, 16'h001F, 32'h1234_5678);
      wr(2'h3, 16'h0021, 32'h1234_5678);
      wr(2'h3, 16'h0000, 32'h0000_0001);
      rd(2'h3, 16'h0000, 32'h0000_0001);
      chk({24'h00_0000, bitstream_ordinal_o}, 32'h0000_0081);
      chk(bitstream_location_o[255:224], 32'hDEAD_BEEF);
      chk(bitstream_length_o[255:224], 32'hFFFF_FFFF);
      rd(2'h3, 16'h001D, 32'hDEAD_BEEF);
      rd(2'h3, 16'h001E, 32'hFFFF_FFFF);
      rd(2'h3, 16'h001C, 32'h0000_0001);
      rd(2'h3, 16'h001F, 32'h0000_0000);
      rd(2'h3, 16'h0021, 32'h0000_0000);
      @(posedge clk_i) shutdown_i <= 1'b0;
      wr(2'h3, 16'h001D, 32'h0000_0000);
      rd(2'h3, 16'h001D, 32'h0000_0000);
      @(posedge clk_i) shutdown_i <= 1'b1;
      rd(2'h3, 16'h001D, 32'hDEAD_BEEF);
      $display("bitstream info test done");
   endtask
   task automatic t_rst;
      @(posedge clk_i) sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk({24'h00_0000, trigger_map_entry_o}, 32'h0000_0000);
      chk(bitstream_location_o[255:224], 32'h0000_0000);
      chk(bitstream_length_o[255:224], 32'h0000_0000);
      rd(2'h2, 16'h0004, 32'h0000_0000);
      $display("reset test done");
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_trig();
      t_mod();
      t_bs();
      t_rst();
      end_sim();
   end
   initial
   begin
      repeat (3000) @(posedge clk_i);
      n_mismatch++;
      end_sim();
   end
endmodule
